// ---- hw/byte_fifo.v ----
// Small synchronous FIFO with valid/ready on both sides and a flush.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ns

module byte_fifo #(
  parameter WIDTH  = 8,
  parameter DEPTH  = 4,
  parameter ADDR_W = 2
) (
  // Clock and reset
  input  wire             mclk,
  input  wire             reset,
  input  wire             flush,
  // Fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // Drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [ADDR_W:0]  wrPtr_r;
  reg [ADDR_W:0]  rdPtr_r;

  wire fullNow  = (wrPtr_r[ADDR_W] != rdPtr_r[ADDR_W]) &&
                  (wrPtr_r[ADDR_W-1:0] == rdPtr_r[ADDR_W-1:0]);
  wire emptyNow = (wrPtr_r == rdPtr_r);

  assign inReady  = ~fullNow;
  assign outValid = ~emptyNow;
  assign outData  = store[rdPtr_r[ADDR_W-1:0]];

  always @(posedge mclk) begin
    if (inValid && !fullNow) begin
      store[wrPtr_r[ADDR_W-1:0]] <= inData;
    end
  end

  always @(posedge mclk) begin
    if (reset || flush) begin
      wrPtr_r <= {(ADDR_W+1){1'b0}};
      rdPtr_r <= {(ADDR_W+1){1'b0}};
    end else begin
      if (inValid && !fullNow) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (outReady && !emptyNow) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end

endmodule

// ---- hw/volatile_read_config.v ----
// Serial front end of the flash holding the volatile read-setup register,
// its download into the internal configuration, and the quick-read path.
// Assumes a mode-0 serial host on sclk/csN/dataIn, slow against mclk.
`timescale 1ns/1ns
`include "volatile_read_consts.vh"

module volatile_read_config (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset,
  // Serial link
  input  wire        sclk,
  input  wire        csN,
  input  wire        dataIn,
  output reg         dataOut_r,
  output reg         dataOe_r,
  // Internal configuration in force
  output reg  [3:0]  dummyCycles_r,
  output reg         executeInPlace_r,
  output reg  [1:0]  wrapMode_r
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam ST_CMD   = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_DUMMY = 3'h2;
  localparam ST_OUT   = 3'h3;
  localparam ST_WRITE = 3'h4;
  localparam ST_SKIP  = 3'h5;

  localparam SRC_ARRAY = 2'h0;
  localparam SRC_SETUP = 2'h1;
  localparam SRC_TUNE  = 2'h2;

  // --------------------------------------------------------------------------
  // Synchronisers and edge detection
  // --------------------------------------------------------------------------
  reg sclkS1_r, sclkS2_r, sclkS3_r;
  reg csS1_r, csS2_r, csS3_r;
  reg dinS1_r, dinS2_r;

  always @(posedge mclk) begin
    if (reset) begin
      sclkS1_r <= 1'b0;
      sclkS2_r <= 1'b0;
      sclkS3_r <= 1'b0;
      csS1_r   <= 1'b1;
      csS2_r   <= 1'b1;
      csS3_r   <= 1'b1;
      dinS1_r  <= 1'b0;
      dinS2_r  <= 1'b0;
    end else begin
      sclkS1_r <= sclk;
      sclkS2_r <= sclkS1_r;
      sclkS3_r <= sclkS2_r;
      csS1_r   <= csN;
      csS2_r   <= csS1_r;
      csS3_r   <= csS2_r;
      dinS1_r  <= dataIn;
      dinS2_r  <= dinS1_r;
    end
  end

  wire sclkRise = sclkS2_r & ~sclkS3_r & ~csS2_r;
  wire sclkFall = ~sclkS2_r & sclkS3_r & ~csS2_r;
  wire frameEnd = csS2_r & ~csS3_r;

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [7:0]  setup_r;
  reg         download_r;
  reg  [2:0]  state_r;
  reg  [4:0]  bitCnt_r;
  reg  [23:0] shiftIn_r;
  reg  [7:0]  shiftOut_r;
  reg  [2:0]  outCnt_r;
  reg  [1:0]  src_r;
  reg  [1:0]  tuneIdx_r;
  reg         writeDone_r;
  reg         skipArm_r;
  reg         skipCmd_r;
  reg  [23:0] fetchAddr_r;
  reg         fetchOn_r;

  wire [23:0] shiftNext = {shiftIn_r[22:0], dinS2_r};
  wire [4:0]  bitNext   = bitCnt_r + 5'h01;

  // Dummy count in force: zero and all-ones both take the command default
  wire [3:0]  dummyUsed = (dummyCycles_r == `DUMMY_ZERO ||
                           dummyCycles_r == `DUMMY_DEFAULT) ?
                          `DUMMY_FAST_DEF : dummyCycles_r;

  // --------------------------------------------------------------------------
  // Array fetch into the FIFO
  // --------------------------------------------------------------------------
  wire        fifoInReady;
  wire        fifoOutValid;
  wire [7:0]  fifoOutData;
  wire        fifoPop = (state_r == ST_OUT) && sclkFall && (outCnt_r == 3'h0) &&
                        (src_r == SRC_ARRAY);
  wire        fifoFlush = frameEnd;
  // Array content stands in as a fixed function of the byte address
  wire [7:0]  arrayByte = fetchAddr_r[7:0] ^ fetchAddr_r[15:8] ^ fetchAddr_r[23:16];

  reg  [23:0] wrapMask;
  always @* begin
    case (wrapMode_r)
      `WRAP_16: wrapMask = `MASK_16;
      `WRAP_32: wrapMask = `MASK_32;
      `WRAP_64: wrapMask = `MASK_64;
      default:  wrapMask = 24'h000000;
    endcase
  end

  wire [23:0] addrInc  = fetchAddr_r + 24'h000001;
  // Block base keeps the high bits, so no byte outside the block is fetched
  wire [23:0] addrNext = (wrapMode_r == `WRAP_CONT) ? addrInc :
                         ((fetchAddr_r & ~wrapMask) | (addrInc & wrapMask));

  byte_fifo #(
    .WIDTH  (8),
    .DEPTH  (4),
    .ADDR_W (2)
  ) u_fifo (
    .mclk     (mclk),
    .reset    (reset),
    .flush    (fifoFlush),
    .inValid  (fetchOn_r),
    .inReady  (fifoInReady),
    .inData   (arrayByte),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  // --------------------------------------------------------------------------
  // Next output byte
  // --------------------------------------------------------------------------
  reg [7:0] tuneByte;
  reg [7:0] nextByte;
  always @* begin
    case (tuneIdx_r)
      2'h0:    tuneByte = `TUNE_B0;
      2'h1:    tuneByte = `TUNE_B1;
      2'h2:    tuneByte = `TUNE_B2;
      default: tuneByte = `TUNE_B3;
    endcase
    case (src_r)
      SRC_ARRAY: nextByte = fifoOutValid ? fifoOutData : 8'hFF;
      SRC_SETUP: nextByte = setup_r;
      default:   nextByte = tuneByte;
    endcase
  end

  // --------------------------------------------------------------------------
  // Register and internal configuration
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      setup_r          <= `SETUP_RESET;
      download_r       <= 1'b0;
      dummyCycles_r    <= `DUMMY_DEFAULT;
      executeInPlace_r <= 1'b0;
      wrapMode_r       <= `WRAP_CONT;
    end else begin
      download_r <= 1'b0;
      if (frameEnd && writeDone_r) begin
        setup_r    <= shiftIn_r[7:0] & ~(8'h01 << `SETUP_FIXED_BIT);
        download_r <= 1'b1;
      end
      if (download_r) begin
        dummyCycles_r    <= setup_r[`SETUP_DUMMY_HI:`SETUP_DUMMY_LO];
        executeInPlace_r <= ~setup_r[`SETUP_INPL_BIT];
        wrapMode_r       <= setup_r[`SETUP_WRAP_HI:`SETUP_WRAP_LO];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      state_r     <= ST_CMD;
      bitCnt_r    <= 5'h00;
      shiftIn_r   <= 24'h000000;
      shiftOut_r  <= 8'h00;
      outCnt_r    <= 3'h0;
      src_r       <= SRC_ARRAY;
      tuneIdx_r   <= 2'h0;
      writeDone_r <= 1'b0;
      skipArm_r   <= 1'b0;
      skipCmd_r   <= 1'b0;
      fetchAddr_r <= 24'h000000;
      fetchOn_r   <= 1'b0;
      dataOut_r   <= 1'b0;
      dataOe_r    <= 1'b0;
    end else if (csS2_r) begin
      // Deselected: next frame opens with a command, or an address in execute-in-place
      state_r     <= skipCmd_r ? ST_ADDR : ST_CMD;
      bitCnt_r    <= 5'h00;
      outCnt_r    <= 3'h0;
      tuneIdx_r   <= 2'h0;
      fetchOn_r   <= 1'b0;
      dataOe_r    <= 1'b0;
      if (frameEnd) begin
        writeDone_r <= 1'b0;
      end
    end else begin
      if (fetchOn_r && fifoInReady) begin
        fetchAddr_r <= addrNext;
      end
      case (state_r)
        ST_CMD: begin
          if (sclkRise) begin
            shiftIn_r <= shiftNext;
            bitCnt_r  <= bitNext;
            if (bitNext == `CMD_BITS) begin
              bitCnt_r <= 5'h00;
              case (shiftNext[7:0])
                `CMD_WRITE_SETUP: state_r <= ST_WRITE;
                `CMD_READ_SETUP: begin
                  state_r <= ST_OUT;
                  src_r   <= SRC_SETUP;
                end
                `CMD_QUICK_READ: begin
                  state_r <= ST_ADDR;
                  src_r   <= SRC_ARRAY;
                end
                `CMD_TUNE_READ: begin
                  state_r <= ST_OUT;
                  src_r   <= SRC_TUNE;
                end
                default: state_r <= ST_SKIP;
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (sclkRise) begin
            shiftIn_r <= shiftNext;
            bitCnt_r  <= bitNext;
            if (bitNext == `ADDR_BITS) begin
              bitCnt_r    <= 5'h00;
              fetchAddr_r <= shiftNext;
              fetchOn_r   <= 1'b1;
              src_r       <= SRC_ARRAY;
              state_r     <= ST_DUMMY;
            end
          end
        end
        ST_DUMMY: begin
          if (sclkRise) begin
            bitCnt_r <= bitNext;
            // First dummy bit low confirms execute-in-place for the next frame
            if (bitCnt_r == 5'h00) begin
              skipArm_r <= executeInPlace_r & ~dinS2_r;
            end
            if (bitNext == {1'b0, dummyUsed}) begin
              bitCnt_r <= 5'h00;
              state_r  <= ST_OUT;
            end
          end
        end
        ST_OUT: begin
          if (sclkFall) begin
            dataOe_r <= 1'b1;
            if (outCnt_r == 3'h0) begin
              dataOut_r  <= nextByte[7];
              shiftOut_r <= {nextByte[6:0], 1'b0};
              outCnt_r   <= 3'h7;
              if (src_r == SRC_TUNE) begin
                tuneIdx_r <= tuneIdx_r + 2'h1;
              end
            end else begin
              dataOut_r  <= shiftOut_r[7];
              shiftOut_r <= {shiftOut_r[6:0], 1'b0};
              outCnt_r   <= outCnt_r - 3'h1;
            end
          end
        end
        ST_WRITE: begin
          if (sclkRise && !writeDone_r) begin
            shiftIn_r <= shiftNext;
            bitCnt_r  <= bitNext;
            if (bitNext == `DATA_BITS) begin
              writeDone_r <= 1'b1;
            end
          end
        end
        default: begin
          dataOe_r <= 1'b0;
        end
      endcase
    end
    if (!reset && frameEnd) begin
      skipCmd_r <= skipArm_r & executeInPlace_r;
      skipArm_r <= 1'b0;
    end
  end

endmodule

// ---- include/volatile_read_consts.vh ----
// Constants for the volatile read-setup register block and its serial front end.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef VOLATILE_READ_CONSTS_VH
`define VOLATILE_READ_CONSTS_VH

// ----------------------------------------------------------------------------
// Register layout
// ----------------------------------------------------------------------------
`define SETUP_RESET      8'hFB
`define SETUP_DUMMY_HI   7
`define SETUP_DUMMY_LO   4
`define SETUP_INPL_BIT   3
`define SETUP_FIXED_BIT  2
`define SETUP_WRAP_HI    1
`define SETUP_WRAP_LO    0

// ----------------------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------------------
`define DUMMY_ZERO       4'h0
`define DUMMY_DEFAULT    4'hF
`define DUMMY_FAST_DEF   4'h8
`define WRAP_16          2'h0
`define WRAP_32          2'h1
`define WRAP_64          2'h2
`define WRAP_CONT        2'h3
`define MASK_16          24'h00000F
`define MASK_32          24'h00001F
`define MASK_64          24'h00003F

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define CMD_WRITE_SETUP  8'h81
`define CMD_READ_SETUP   8'h85
`define CMD_QUICK_READ   8'h0B
`define CMD_TUNE_READ    8'h5A

// ----------------------------------------------------------------------------
// Framing counts and tuning pattern
// ----------------------------------------------------------------------------
`define CMD_BITS         5'h08
`define ADDR_BITS        5'h18
`define DATA_BITS        5'h08
`define TUNE_B0          8'h00
`define TUNE_B1          8'hFF
`define TUNE_B2          8'h55
`define TUNE_B3          8'hAA

`endif

// ---- verif/spi_host_model.sv ----
// Serial host model: mode 0, sclk period 8 mclk (160 ns), MSB first.
// Assumes the device drives dataOut only while dataOe is high.
`timescale 1ns/1ns
module spi_host_model (
  // Clock
  input  wire mclk,
  // Serial link
  output reg  sclk,
  output reg  csN,
  output reg  dataIn,
  input  wire dataOut,
  input  wire dataOe
);
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    dataIn = 1'b0;
  end
  task start;
    begin
      @(posedge mclk) csN <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
  // Clocks n bits of tx; slow clock keeps every dummy count legal
  task xfer(input [7:0] tx, input integer n, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge mclk) sclk <= 1'b0;
        dataIn <= tx[7-i];
        repeat (3) @(posedge mclk);
        @(posedge mclk) sclk <= 1'b1;
        @(posedge mclk) rx = {rx[6:0], dataOe ? dataOut : 1'bx};
        repeat (2) @(posedge mclk);
      end
    end
  endtask
  // Released data line shows the inverse of its last value
  task stop;
    begin
      @(posedge mclk) sclk <= 1'b0;
      repeat (4) @(posedge mclk);
      csN <= 1'b1;
      dataIn <= ~dataIn;
      repeat (8) @(posedge mclk);
    end
  endtask
endmodule

// ---- verif/volatile_read_config_sva.sv ----
// Checker for the volatile read-setup block, bound to its top module.
// Assumes a serial host whose sclk is slow against mclk.
`timescale 1ns/1ns
module volatile_read_config_sva (
  // Clock and reset
  input wire       mclk,
  input wire       reset,
  // Serial link
  input wire       sclk,
  input wire       csN,
  input wire       dataIn,
  input wire       dataOut_r,
  input wire       dataOe_r,
  // Configuration in force
  input wire [3:0] dummyCycles_r,
  input wire       executeInPlace_r,
  input wire [1:0] wrapMode_r
);
  reg [3:0] sinceFall_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Cycles since the last serial clock fall
  always @(posedge mclk) begin
    if (reset || $fell(sclk))
      sinceFall_r <= 4'h0;
    else if (sinceFall_r != 4'hF)
      sinceFall_r <= sinceFall_r + 4'h1;
  end
  sequence frameEnd;
    dataOe_r ##1 csN [*2];
  endsequence
  sequence bitShift;
    dataOe_r && $past(dataOe_r) && $changed(dataOut_r);
  endsequence
  a_reset_values: assert property (
    $fell(reset) |-> dummyCycles_r == 4'hF && wrapMode_r == 2'h3 && !executeInPlace_r)
    else $error("config not at defaults after reset");
  a_cfg_after_frame: assert property (
    $changed({dummyCycles_r, executeInPlace_r, wrapMode_r}) |-> csN && $past(csN, 3))
    else $error("config changed inside a frame");
  a_oe_idle_off: assert property (
    csN [*5] |-> !dataOe_r)
    else $error("output enabled while deselected");
  a_oe_in_frame: assert property (
    $rose(dataOe_r) |-> !$past(csN, 3))
    else $error("output enabled without a frame");
  a_oe_hold: assert property (
    (dataOe_r && !csN) ##1 !csN |-> dataOe_r)
    else $error("output dropped inside a frame");
  a_oe_fall_cause: assert property (
    $fell(dataOe_r) |-> $past(csN, 2))
    else $error("output dropped while selected");
  a_oe_prompt: assert property (
    frameEnd |-> ##[1:5] !dataOe_r)
    else $error("output not released after frame");
  a_out_after_fall: assert property (
    bitShift |-> sinceFall_r >= 4'h1 && sinceFall_r <= 4'h6)
    else $error("output bit changed away from sclk fall");
endmodule

bind volatile_read_config volatile_read_config_sva chk (
  .mclk(mclk), .reset(reset), .sclk(sclk), .csN(csN), .dataIn(dataIn),
  .dataOut_r(dataOut_r), .dataOe_r(dataOe_r), .dummyCycles_r(dummyCycles_r),
  .executeInPlace_r(executeInPlace_r), .wrapMode_r(wrapMode_r));

// ---- verif/volatile_read_config_tb.sv ----
// Self-checking bench for the volatile read-setup block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ns
`include "volatile_read_consts.vh"
module volatile_read_config_tb;
  reg         mclk = 1'b0;
  reg         reset = 1'b1;
  wire        sclk, csN, dataIn, dataOut_r, dataOe_r;
  wire [3:0]  dummyCycles_r;
  wire        executeInPlace_r;
  wire [1:0]  wrapMode_r;
  reg  [7:0]  rx;
  integer     n_fail = 0, checked = 0, cycles = 0;
  always #10 mclk = ~mclk;
  volatile_read_config uut (.mclk(mclk), .reset(reset), .sclk(sclk), .csN(csN),
    .dataIn(dataIn), .dataOut_r(dataOut_r), .dataOe_r(dataOe_r),
    .dummyCycles_r(dummyCycles_r), .executeInPlace_r(executeInPlace_r),
    .wrapMode_r(wrapMode_r));
  spi_host_model host (.mclk(mclk), .sclk(sclk), .csN(csN), .dataIn(dataIn),
    .dataOut(dataOut_r), .dataOe(dataOe_r));
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task cmp8(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] v);
    begin
      host.start;
      host.xfer(`CMD_WRITE_SETUP, 8, rx);
      host.xfer(v, 8, rx);
      host.stop;
    end
  endtask
  task rd_setup(input [7:0] exp);
    begin
      host.start;
      host.xfer(`CMD_READ_SETUP, 8, rx);
      host.xfer(8'h00, 8, rx);
      cmp8(rx, exp);
      host.xfer(8'h00, 8, rx);
      cmp8(rx, exp);
      host.stop;
    end
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task t_reset_values;
    begin
      rd_setup(`SETUP_RESET);
      cmp8({1'b0, dummyCycles_r, executeInPlace_r, wrapMode_r}, 8'h7B);
    end
  endtask
  task t_setup_table;
    reg [31:0] tbl;
    reg [7:0]  v;
    integer    i;
    begin
      tbl = 32'h0419E2FF;
      for (i = 0; i < 4; i = i + 1) begin
        v = tbl[31-8*i -: 8];
        wr(v);
        cmp8({1'b0, dummyCycles_r, executeInPlace_r, wrapMode_r},
             {1'b0, v[7:4], ~v[3], v[1:0]});
        rd_setup(v & 8'hFB);
      end
      host.start;
      host.xfer(`CMD_WRITE_SETUP, 8, rx);
      host.xfer(8'h00, 4, rx);
      host.stop;
      rd_setup(8'hFB);
    end
  endtask
  task t_quick_reads;
    reg [127:0] tbl;
    reg [31:0]  e;
    reg [23:0]  a, m;
    integer     i, j, n;
    begin
      tbl = {32'hF812340E, 32'h0912341E, 32'hEA12343E, 32'h1B12FFFE};
      for (i = 0; i < 4; i = i + 1) begin
        e = tbl[127-32*i -: 32];
        wr(e[31:24]);
        a = e[23:0];
        m = (e[25:24] == `WRAP_16) ? `MASK_16 :
            (e[25:24] == `WRAP_32) ? `MASK_32 : `MASK_64;
        n = (e[31:28] == `DUMMY_ZERO || e[31:28] == `DUMMY_DEFAULT) ?
            `DUMMY_FAST_DEF : e[31:28];
        host.start;
        host.xfer(`CMD_QUICK_READ, 8, rx);
        for (j = 16; j >= 0; j = j - 8)
          host.xfer(a[j+:8], 8, rx);
        while (n > 0) begin
          host.xfer(8'hFF, (n > 8) ? 8 : n, rx);
          n = n - 8;
        end
        for (j = 0; j < 5; j = j + 1) begin
          host.xfer(8'h00, 8, rx);
          cmp8(rx, a[7:0] ^ a[15:8] ^ a[23:16]);
          a = (e[25:24] == `WRAP_CONT) ? a + 24'h1 : (a & ~m) | ((a + 24'h1) & m);
        end
        host.stop;
      end
    end
  endtask
  task t_tune;
    reg [31:0] p;
    integer    j;
    begin
      p = {`TUNE_B0, `TUNE_B1, `TUNE_B2, `TUNE_B3};
      host.start;
      host.xfer(`CMD_TUNE_READ, 8, rx);
      for (j = 0; j < 8; j = j + 1) begin
        host.xfer(8'h00, 8, rx);
        cmp8(rx, p[31-8*(j%4) -: 8]);
      end
      host.stop;
      // Unknown command: rest of frame ignored, output stays released
      host.start;
      host.xfer(8'h00, 8, rx);
      host.xfer(8'h00, 8, rx);
      cmp8({7'h00, dataOe_r}, 8'h00);
      host.stop;
    end
  endtask
  task t_in_place;
    begin
      wr(8'hF3);
      cmp8({7'h00, executeInPlace_r}, 8'h01);
      host.start;
      host.xfer(`CMD_QUICK_READ, 8, rx);
      host.xfer(8'h00, 8, rx);
      host.xfer(8'h00, 8, rx);
      host.xfer(8'h10, 8, rx);
      host.xfer(8'h7F, 8, rx);
      host.xfer(8'h00, 8, rx);
      cmp8(rx, 8'h10);
      host.stop;
      host.start;
      host.xfer(8'h00, 8, rx);
      host.xfer(8'h01, 8, rx);
      host.xfer(8'h20, 8, rx);
      host.xfer(8'hFF, 8, rx);
      host.xfer(8'h00, 8, rx);
      cmp8(rx, 8'h21);
      host.stop;
      rd_setup(8'hF3);
      wr(`SETUP_RESET);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    t_reset_values;
    t_setup_table;
    t_quick_reads;
    t_tune;
    t_in_place;
    print_verdict;
  end
endmodule
